/* core/pssp_pkg.sv */
// Types shared by the pipelined synchronous SRAM port.
`include "pssp_regs.svh"
package pssp_pkg;
   typedef logic [`PSSP_ADDR_W-1:0] pssp_addr_t;
   typedef logic [`PSSP_CNT_W-1:0] pssp_cnt_t;
   typedef logic [`PSSP_PAR_W-1:0] pssp_lane_t;

   typedef struct packed {
      logic [`PSSP_PAR_W-1:0] par;
      logic [`PSSP_DATA_W-1:0] dat;
   } pssp_word_t;

   typedef struct packed {
      logic valid;
      logic write;
      pssp_lane_t lanes;
      pssp_addr_t addr;
   } pssp_op_t;

   typedef struct packed {
      pssp_lane_t lanes;
      pssp_addr_t addr;
      pssp_word_t word;
   } pssp_wr_t;

   typedef enum logic {
      PSSP_ORDER_LINEAR = 1'b0,
      PSSP_ORDER_INTERLEAVED = 1'b1
   } pssp_order_t;
endpackage : pssp_pkg

/* core/pssp_port.sv */
// Pipelined synchronous burst SRAM port with common data and parity I/O.
`timescale 1ns/1ps
`default_nettype none
`include "pssp_regs.svh"
module pssp_port (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Control inputs.
   input wire logic clock_qualifier_n_in,
   input wire logic chip_select_a_n_in,
   input wire logic chip_select_b_in,
   input wire logic chip_select_c_n_in,
   input wire logic write_strobe_n_in,
   input wire logic burst_step_or_reload_in,
   input wire pssp_pkg::pssp_lane_t lane_write_mask_n_in,
   input wire pssp_pkg::pssp_addr_t addr_in,
   input wire logic burst_order_in,
   input wire logic drive_enable_n_in,
   // Data pins.
   input wire logic [`PSSP_DATA_W-1:0] data_in,
   output logic [`PSSP_DATA_W-1:0] data_out,
   output logic data_oe_n_out,
   // Parity pins.
   input wire logic [`PSSP_PAR_W-1:0] parity_in,
   output logic [`PSSP_PAR_W-1:0] parity_out,
   output logic parity_oe_n_out
);
   import pssp_pkg::*;

   // Write storage, one array per byte lane with its parity bit.
   logic [`PSSP_LANE_W-1:0] mem_lo [`PSSP_DEPTH];
   logic [`PSSP_LANE_W-1:0] mem_hi [`PSSP_DEPTH];

   pssp_op_t s1;
   pssp_op_t s2;
   pssp_addr_t base;
   pssp_cnt_t cnt;
   pssp_cnt_t next_cnt;
   logic burst_live;
   logic burst_write;
   pssp_word_t rd_q;
   logic drive_q;
   pssp_wr_t buf_ent [`PSSP_BUF_DEPTH];
   logic wp;
   logic rp;
   logic [1:0] fill;
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic step;
   logic cs_ok;
   pssp_wr_t incoming;
   pssp_word_t rd_word;

   // Address of a burst beat in the selected order.
   function automatic pssp_addr_t burst_addr(input pssp_addr_t b, input pssp_cnt_t c,
                                             input logic order);
      pssp_addr_t a;
      a = b;
      if (order == PSSP_ORDER_INTERLEAVED) begin
         a[`PSSP_CNT_W-1:0] = b[`PSSP_CNT_W-1:0] ^ c;
      end else begin
         a[`PSSP_CNT_W-1:0] = pssp_cnt_t'(b[`PSSP_CNT_W-1:0] + c);
      end
      return a;
   endfunction : burst_addr

   // Overlays a pending write onto a read word when the address matches.
   function automatic pssp_word_t overlay(input pssp_word_t w, input pssp_wr_t e,
                                          input logic v, input pssp_addr_t a);
      pssp_word_t r;
      r = w;
      if (v && e.addr == a) begin
         if (e.lanes[0]) begin
            r.dat[7:0] = e.word.dat[7:0];
            r.par[0] = e.word.par[0];
         end
         if (e.lanes[1]) begin
            r.dat[15:8] = e.word.dat[15:8];
            r.par[1] = e.word.par[1];
         end
      end
      return r;
   endfunction : overlay

   assign step = ~clock_qualifier_n_in & buf_in_ready;
   assign cs_ok = ~chip_select_a_n_in & chip_select_b_in & ~chip_select_c_n_in;
   assign next_cnt = pssp_cnt_t'(cnt + `PSSP_CNT_ONE);

   // Issue stage: load or advance, then register the operation.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1 <= '0;
         base <= '0;
         cnt <= `PSSP_CNT_ZERO;
         burst_live <= 1'b0;
         burst_write <= 1'b0;
      end else if (step) begin
         if (!burst_step_or_reload_in) begin
            s1.valid <= cs_ok;
            s1.write <= cs_ok & ~write_strobe_n_in;
            s1.addr <= addr_in;
            s1.lanes <= write_strobe_n_in ? `PSSP_LANE_NONE : ~lane_write_mask_n_in;
            base <= addr_in;
            cnt <= `PSSP_CNT_ZERO;
            burst_live <= cs_ok;
            burst_write <= cs_ok & ~write_strobe_n_in;
         end else begin
            cnt <= next_cnt;
            s1.valid <= burst_live;
            s1.write <= burst_write;
            s1.addr <= burst_addr(base, next_cnt, burst_order_in);
            s1.lanes <= burst_write ? ~lane_write_mask_n_in : `PSSP_LANE_NONE;
         end
      end
   end

   // Second stage: the data phase of every operation.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s2 <= '0;
      end else if (step) begin
         s2 <= s1;
      end
   end

   // Write buffer: captures the data pins and drains into storage.
   assign incoming.lanes = s2.lanes;
   assign incoming.addr = s2.addr;
   assign incoming.word = '{par: parity_in, dat: data_in};
   assign buf_in_valid = step & s2.valid & s2.write;
   assign buf_in_ready = (fill != 2'(`PSSP_BUF_DEPTH));
   assign buf_out_valid = (fill != 2'h0);
   assign buf_out_ready = ~clock_qualifier_n_in;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wp <= 1'b0;
         rp <= 1'b0;
         fill <= 2'h0;
      end else begin
         if (buf_in_valid) begin
            wp <= ~wp;
         end
         if (buf_out_valid && buf_out_ready) begin
            rp <= ~rp;
         end
         fill <= 2'(fill + 2'(buf_in_valid) - 2'(buf_out_valid & buf_out_ready));
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (buf_in_valid) begin
         buf_ent[wp] <= incoming;
      end
   end

   // Drains the oldest buffered write into the lane arrays.
   always_ff @(posedge ref_clk_in) begin
      if (buf_out_valid && buf_out_ready) begin
         if (buf_ent[rp].lanes[0]) begin
            mem_lo[buf_ent[rp].addr] <= {buf_ent[rp].word.par[0], buf_ent[rp].word.dat[7:0]};
         end
         if (buf_ent[rp].lanes[1]) begin
            mem_hi[buf_ent[rp].addr] <= {buf_ent[rp].word.par[1], buf_ent[rp].word.dat[15:8]};
         end
      end
   end

   // Read lookup with older writes still in flight applied in order.
   always_comb begin
      rd_word = '{par: {mem_hi[s1.addr][8], mem_lo[s1.addr][8]},
                  dat: {mem_hi[s1.addr][7:0], mem_lo[s1.addr][7:0]}};
      rd_word = overlay(rd_word, buf_ent[rp], fill != 2'h0, s1.addr);
      rd_word = overlay(rd_word, buf_ent[~rp], fill == 2'h2, s1.addr);
      rd_word = overlay(rd_word, incoming, buf_in_valid, s1.addr);
   end

   // Output register and internal drive state.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_q <= '0;
         drive_q <= 1'b0;
      end else if (step) begin
         if (s1.valid && !s1.write) begin
            rd_q <= rd_word;
         end
         drive_q <= s1.valid & ~s1.write;
      end
   end

   assign data_out = rd_q.dat;
   assign parity_out = rd_q.par;
   assign data_oe_n_out = ~drive_q | drive_enable_n_in;
   assign parity_oe_n_out = ~drive_q | drive_enable_n_in;

   chk_freeze_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      clock_qualifier_n_in |=> ($stable(s1) && $stable(s2) && $stable(drive_q)))
      else $error("state changed on an unqualified edge");

   chk_start_latch: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !burst_step_or_reload_in && cs_ok) |=> (s1.valid && s1.addr == $past(addr_in)))
      else $error("start address not latched");

   chk_direction_pick: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !burst_step_or_reload_in && cs_ok) |=> (s1.write == !$past(write_strobe_n_in)))
      else $error("access direction wrong");

   chk_desel_no_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !burst_step_or_reload_in && !cs_ok) |=> !s1.valid)
      else $error("access started while deselected");

   chk_read_data_out: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && s1.valid && !s1.write) ##1 (!drive_enable_n_in) |-> !data_oe_n_out)
      else $error("read data not driven one clock after lookup");

   chk_write_tristate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && (s1.write || !s1.valid)) |=> (data_oe_n_out && parity_oe_n_out))
      else $error("outputs driven in write or deselect cycle");

   chk_drive_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      drive_enable_n_in |-> (data_oe_n_out && parity_oe_n_out))
      else $error("outputs driven with drive enable high");

   chk_burst_linear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && burst_step_or_reload_in && burst_order_in == PSSP_ORDER_LINEAR)
      |=> (s1.addr[1:0] == 2'($past(base[1:0]) + $past(cnt) + 2'h1)))
      else $error("linear burst address wrong");

   chk_mask_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !burst_step_or_reload_in && write_strobe_n_in) |=> (s1.lanes == 2'h0))
      else $error("lanes enabled on a read");

   chk_write_capture: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && s1.valid && s1.write) |=> (s2.valid && s2.write))
      else $error("write did not reach its data stage");

   chk_write_data: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && s2.valid && s2.write) |-> buf_in_valid)
      else $error("write data not captured two qualified clocks after start");

   chk_stage_advance: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      step |=> (s2 == $past(s1)))
      else $error("pipeline stage did not advance");

   chk_freeze_output: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      clock_qualifier_n_in |=> ($stable(rd_q) && $stable(cnt) && $stable(base) && $stable(fill)))
      else $error("output or burst state changed on an unqualified edge");

   chk_hold_no_desel: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (clock_qualifier_n_in && drive_q) |=> drive_q)
      else $error("qualifier high deselected the outputs");

   chk_burst_count: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && burst_step_or_reload_in) |=> (cnt == 2'($past(cnt) + 2'h1)))
      else $error("burst counter did not advance");

   chk_reload_base: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !burst_step_or_reload_in) |=> (cnt == 2'h0 && base == $past(addr_in)))
      else $error("reload did not restart the burst");

   chk_burst_inter: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && burst_step_or_reload_in && burst_order_in == PSSP_ORDER_INTERLEAVED)
      |=> (s1.addr[1:0] == ($past(base[1:0]) ^ 2'($past(cnt) + 2'h1))))
      else $error("interleaved burst address wrong");

   chk_burst_upper: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && burst_step_or_reload_in) |=> (s1.addr[17:2] == $past(base[17:2])))
      else $error("burst left its four-word group");

   chk_burst_kind: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && burst_step_or_reload_in)
      |=> (s1.valid == $past(burst_live) && s1.write == $past(burst_write)))
      else $error("burst beat changed its access type");

   chk_write_lanes: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !burst_step_or_reload_in && cs_ok && !write_strobe_n_in)
      |=> (s1.lanes == ~$past(lane_write_mask_n_in)))
      else $error("write lanes do not follow the masks");

   chk_read_register: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && s1.valid && !s1.write) |=> (rd_q == $past(rd_word)))
      else $error("read word not registered");

   chk_parity_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      data_oe_n_out == parity_oe_n_out)
      else $error("parity drive differs from data drive");

   chk_data_capture: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      buf_in_valid |=> (buf_ent[$past(wp)] == $past(incoming)))
      else $error("write data not captured");

   chk_no_stall: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      !clock_qualifier_n_in |-> buf_in_ready)
      else $error("write buffer stalled a qualified edge");

   chk_fill_bound: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      fill != 2'h2)
      else $error("write buffer backed up");

   chk_desel_tristate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !s1.valid) |=> !drive_q)
      else $error("drive state kept after deselect");

   chk_read_lanes: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && burst_step_or_reload_in && !burst_write) |=> (s1.lanes == 2'h0))
      else $error("lanes enabled on a read burst");

   chk_desel_no_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && !burst_step_or_reload_in && !cs_ok) |=> !s1.write)
      else $error("write started while deselected");

   chk_drive_pipe: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && s1.valid && !s1.write) |=> drive_q)
      else $error("read did not reach the drive stage");

   chk_drive_open: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (drive_q && !drive_enable_n_in) |-> !data_oe_n_out)
      else $error("outputs not driven with drive enable low");
endmodule : pssp_port
`default_nettype wire

/* core/pssp_regs.svh */
// Constants for the pipelined synchronous SRAM port.
`ifndef PSSP_REGS_SVH
`define PSSP_REGS_SVH
`define PSSP_ADDR_W 18
`define PSSP_DEPTH 262144
`define PSSP_DATA_W 16
`define PSSP_PAR_W 2
`define PSSP_LANE_W 9
`define PSSP_CNT_W 2
`define PSSP_BUF_DEPTH 2
`define PSSP_CNT_ZERO 2'h0
`define PSSP_CNT_ONE 2'h1
`define PSSP_LANE_NONE 2'h0
`endif

/* dv/pssp_ctrl.sv */
// Controller model that drives the port pins and resolves the shared data wire.
`timescale 1ns/1ps
`default_nettype none
module pssp_ctrl (
   // Clock.
   input wire logic clk_in,
   // Device side.
   input wire pssp_pkg::pssp_word_t dev_out_in,
   input wire logic oe_n_in,
   // Pins.
   output logic cq_n_out,
   output logic [2:0] sel_out,
   output logic we_n_out,
   output logic adv_out,
   output pssp_pkg::pssp_lane_t ln_out,
   output pssp_pkg::pssp_addr_t a_out,
   output pssp_pkg::pssp_word_t pin_out
);
   import pssp_pkg::*;
   pssp_word_t wq, w1d, hd, last;
   logic wv, w1, hv;
   initial begin
      {cq_n_out, sel_out, we_n_out, adv_out} = 6'h16;
      {ln_out, a_out, wq, w1d, hd, last} = '0;
      {wv, w1, hv} = 3'h0;
   end
   always @(posedge clk_in) begin
      if (!cq_n_out) begin
         w1 <= wv;
         w1d <= wq;
         hv <= w1;
         hd <= w1d;
      end
      last <= pin_out;
   end
   assign pin_out = hv ? hd : (!oe_n_in ? dev_out_in : ~last);
   task automatic cyc(input logic q, input logic [2:0] s, input logic w, input logic v,
         input pssp_lane_t l, input pssp_addr_t x, input pssp_word_t d);
      @(posedge clk_in);
      cq_n_out <= q;
      sel_out <= s;
      we_n_out <= w;
      adv_out <= v;
      ln_out <= l;
      a_out <= x;
      wv <= !q && !v && s == 3'h2 && !w;
      wq <= d;
   endtask : cyc
endmodule : pssp_ctrl
`default_nettype wire

/* dv/pssp_port_tb.sv */
// Self-checking bench for the pipelined synchronous SRAM port.
`timescale 1ns/1ps
`default_nettype none
module pssp_port_tb;
   import pssp_pkg::*;
   logic clk, rst_n, de_n, cq_n, we_n, adv, doe_n, poe_n, mode;
   logic [2:0] sel;
   logic [15:0] dd;
   logic [1:0] dp;
   pssp_lane_t ln;
   pssp_addr_t a;
   pssp_word_t pin;
   int errors, n_compared;
   pssp_ctrl pssp_ctrl_i (.clk_in(clk), .dev_out_in({dp, dd}), .oe_n_in(doe_n),
      .cq_n_out(cq_n), .sel_out(sel), .we_n_out(we_n), .adv_out(adv), .ln_out(ln),
      .a_out(a), .pin_out(pin));
   pssp_port pssp_port_i (.ref_clk_in(clk), .rst_n_in(rst_n), .clock_qualifier_n_in(cq_n),
      .chip_select_a_n_in(sel[2]), .chip_select_b_in(sel[1]), .chip_select_c_n_in(sel[0]),
      .write_strobe_n_in(we_n), .burst_step_or_reload_in(adv), .lane_write_mask_n_in(ln),
      .addr_in(a), .burst_order_in(mode), .drive_enable_n_in(de_n), .data_in(pin.dat),
      .data_out(dd), .data_oe_n_out(doe_n), .parity_in(pin.par), .parity_out(dp),
      .parity_oe_n_out(poe_n));
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd(input pssp_addr_t x);
      pssp_ctrl_i.cyc(1'b0, 3'h2, 1'b1, 1'b0, 2'h0, x, 18'h0_0000);
   endtask : rd
   task automatic wr(input pssp_addr_t x, input pssp_lane_t l, input pssp_word_t d);
      pssp_ctrl_i.cyc(1'b0, 3'h2, 1'b0, 1'b0, l, x, d);
   endtask : wr
   task automatic nop;
      pssp_ctrl_i.cyc(1'b0, 3'h5, 1'b1, 1'b0, 2'h0, 18'h0_0000, 18'h0_0000);
   endtask : nop
   task automatic ad;
      pssp_ctrl_i.cyc(1'b0, 3'h5, 1'b0, 1'b1, 2'h0, 18'h0_0000, 18'h0_0000);
   endtask : ad
   task automatic hold;
      pssp_ctrl_i.cyc(1'b1, 3'h2, 1'b0, 1'b0, 2'h0, 18'h0_0000, 18'h0_0000);
   endtask : hold
   task automatic look(input pssp_word_t e);
      @(negedge clk);
      chk("read data", e, {dp, dd});
      chk("drive", 18'h0_0000, {16'h0000, doe_n, poe_n});
   endtask : look
   task automatic off;
      @(negedge clk);
      chk("drive off", 18'h0_0003, {16'h0000, doe_n, poe_n});
   endtask : off
   task automatic wrd(input pssp_addr_t x, input pssp_lane_t l, input pssp_word_t d,
         input pssp_word_t e);
      wr(x, l, d);
      rd(x ^ 18'h0_0001);
      rd(x);
      off();
      nop();
      nop();
      look(e);
      nop();
      off();
   endtask : wrd
   task automatic s_lanes;
      pssp_word_t e, d;
      pssp_lane_t l;
      e = 18'h0_0000;
      for (int k = 0; k < 4; k++) begin
         l = 2'(k);
         d.dat = 16'h1234 * 16'(k + 1);
         d.par = 2'(k) ^ 2'h2;
         if (!l[0]) {e.par[0], e.dat[7:0]} = {d.par[0], d.dat[7:0]};
         if (!l[1]) {e.par[1], e.dat[15:8]} = {d.par[1], d.dat[15:8]};
         wrd(18'h2_0040, l, d, e);
      end
   endtask : s_lanes
   task automatic s_sel;
      for (int k = 0; k < 3; k++) begin
         rd(18'h2_0040);
         pssp_ctrl_i.cyc(1'b0, 3'h2 ^ 3'(1 << k), 1'b1, 1'b0, 2'h0, 18'h2_0040, 18'h0_0000);
         nop();
         look(18'h2_249C);
         nop();
         off();
      end
   endtask : s_sel
   task automatic s_oe;
      rd(18'h2_0040);
      nop();
      hold();
      @(negedge clk);
      chk("drive open", 18'h0_0000, {16'h0000, doe_n, poe_n});
      hold();
      de_n <= 1'b1;
      @(negedge clk);
      chk("drive gated", 18'h0_0003, {16'h0000, doe_n, poe_n});
      nop();
      de_n <= 1'b0;
   endtask : s_oe
   task automatic s_hold;
      rd(18'h2_0040);
      hold();
      hold();
      nop();
      off();
      hold();
      look(18'h2_249C);
      hold();
      look(18'h2_249C);
      nop();
      nop();
      off();
   endtask : s_hold
   task automatic s_burst(input logic o);
      pssp_word_t m [4];
      @(posedge clk);
      mode <= o;
      for (int k = 0; k < 4; k++) begin
         m[k] = {2'(k), 16'hC3A0 + 16'(k)};
         wr(18'h3_FFFC + 18'(k), 2'h0, m[k]);
      end
      rd(18'h3_FFFC);
      rd(18'h3_FFFD);
      ad();
      for (int k = 0; k < 4; k++) begin
         if (k < 2) ad();
         else nop();
         look(o ? m[k ^ 1] : m[(k + 1) % 4]);
      end
      nop();
      off();
   endtask : s_burst
   task automatic complete_run;
      if (errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #100000;
      errors++;
      complete_run();
   end
   initial begin
      rst_n = 1'b0;
      de_n = 1'b0;
      mode = 1'b1;
      errors = 0;
      n_compared = 0;
      repeat (16) @(posedge clk);
      chk("reset drive", 18'h0_0003, {16'h0000, doe_n, poe_n});
      rst_n <= 1'b1;
      s_lanes();
      s_sel();
      s_oe();
      s_hold();
      s_burst(1'b1);
      s_burst(1'b0);
      complete_run();
   end
endmodule : pssp_port_tb
`default_nettype wire
